// ---- hdl/fe_cfg_map.svh ----
// Register indices, field positions, reset values and decode constants of the front-end config bank
`ifndef FE_CFG_MAP_SVH
`define FE_CFG_MAP_SVH
// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_GAIN_CTRL 8'hc4
`define IDX_CFG_STATUS 8'hc5
`define IDX_GAIN_PAIR 8'hc9
`define IDX_ATTEN_HPF 8'hcb
`define IDX_CLAMP_OPT 8'hcd
// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_INDEP_GAIN 15
`define BIT_PAIR_OFFSET 0
`define BIT_ATTEN_EN 7
`define LSB_ATTEN_CODE 4
`define LSB_HPF_SEL 2
`define BIT_HALF_CLAMP 15
`define BIT_HARM_FILT 14
`define BIT_CONV_CLAMP 13
`define BIT_DIV3 8
`define BIT_STAT_RSVD 8
// ****************************************************************
// Reset values and decodes
// ****************************************************************
`define REG_RESET 16'h0000
`define GAIN_DB_00 5'h12
`define GAIN_DB_01 5'h18
`define GAIN_DB_10 5'h0c
`define ATTEN_STEP_DB 6'h06
`define HPF_HZ_00 18'h186a0
`define HPF_HZ_01 18'h0c350
`define HPF_HZ_10 18'h30d40
`define HPF_HZ_11 18'h249f0
`define HPF_DIVISOR 18'h00003
`endif

// ---- hdl/fe_cfg_pkg.sv ----
// Types shared by the front-end config bank and its users
package fe_cfg_pkg;
  typedef enum logic [1:0] {
    GAIN_18DB,
    GAIN_24DB,
    GAIN_12DB,
    GAIN_RSVD
  } gain_code_t;

  typedef struct packed {
    logic [7:0] gain_apply;
    logic [7:0][4:0] gain_db;
    logic atten_enable;
    logic [5:0] atten_db;
    logic [17:0] corner_hz;
    logic half_level_clamp;
    logic harmonic_suppress_filter;
    logic converter_stage_clamp;
  } analog_cfg_t;

  typedef struct packed {
    logic hsel;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;
endpackage

// ---- hdl/frontend_gain_filter_config_regs.sv ----
// AHB-Lite register bank for preamp gain, time-gain attenuator and high-pass corner settings
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
`include "fe_cfg_map.svh"
`default_nettype none
module frontend_gain_filter_config_regs #(
  parameter int ADDR_W = 12,
  parameter int PAIRS = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire fe_cfg_pkg::ahb_req_t bus_req,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output fe_cfg_pkg::analog_cfg_t analog_cfg
);
  import fe_cfg_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (ADDR_W != 12) begin : g_bad_addr
    $error("ADDR_W must be 12 to match the request struct");
  end
  if (PAIRS != 4) begin : g_bad_pairs
    $error("PAIRS must be 4: the gain byte holds four pair fields");
  end

  // ****************************************************************
  // Bus address and data phase
  // ****************************************************************
  logic addr_take;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic rd_wait_reg;
  logic [7:0] idx_reg;
  logic [7:0] idx_next;

  assign addr_take = bus_req.hsel && bus_req.htrans[1] && bus_req.hready;
  assign idx_next = bus_req.haddr[9:2];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg <= 8'h00;
    end else if (bus_req.hready) begin
      wr_pend_reg <= addr_take && bus_req.hwrite && (bus_req.haddr[11:10] == 2'h0);
      rd_pend_reg <= addr_take && !bus_req.hwrite;
      idx_reg <= (bus_req.haddr[11:10] == 2'h0) ? idx_next : 8'hff;
    end
  end

  // Reads take one wait state so a write just before is seen, except in the status atten_db field, which is registered one cycle later
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_wait_reg <= 1'b0;
    end else begin
      rd_wait_reg <= rd_pend_reg && !rd_wait_reg;
    end
  end

  assign hreadyout = !(rd_pend_reg && !rd_wait_reg);
  assign hresp = 1'b0;

  logic wr_gain_ctrl;
  logic wr_gain_pair;
  logic wr_atten;
  logic wr_clamp;
  assign wr_gain_ctrl = wr_pend_reg && (idx_reg == `IDX_GAIN_CTRL);
  assign wr_gain_pair = wr_pend_reg && (idx_reg == `IDX_GAIN_PAIR);
  assign wr_atten = wr_pend_reg && (idx_reg == `IDX_ATTEN_HPF);
  assign wr_clamp = wr_pend_reg && (idx_reg == `IDX_CLAMP_OPT);

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic indep_gain_reg;
  logic pair_offset_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      indep_gain_reg <= 1'(`REG_RESET >> `BIT_INDEP_GAIN);
      pair_offset_reg <= 1'(`REG_RESET >> `BIT_PAIR_OFFSET);
    end else if (wr_gain_ctrl) begin
      indep_gain_reg <= bus_req.hwdata[`BIT_INDEP_GAIN];
      pair_offset_reg <= bus_req.hwdata[`BIT_PAIR_OFFSET];
    end
  end

  // ****************************************************************
  // Per-channel gain storage
  // ****************************************************************
  logic [2*PAIRS-1:0][1:0] ch_gain_reg;
  logic [2*PAIRS-1:0] ch_rsvd;

  for (genvar p = 0; p < PAIRS; p++) begin : g_pair
    // pair p sits in bits 2p+1..2p
    // even channel always, odd one only without offset
    always_ff @(posedge clk) begin
      if (!nrst) begin
        ch_gain_reg[2*p+1] <= 2'(`REG_RESET >> (2*p));
      end else if (wr_gain_pair) begin
        ch_gain_reg[2*p+1] <= bus_req.hwdata[2*p+:2];
      end
    end
    always_ff @(posedge clk) begin
      if (!nrst) begin
        ch_gain_reg[2*p] <= 2'(`REG_RESET >> (2*p));
      end else if (wr_gain_pair && !pair_offset_reg) begin
        ch_gain_reg[2*p] <= bus_req.hwdata[2*p+:2];
      end
    end
  end

  for (genvar c = 0; c < 2*PAIRS; c++) begin : g_chan
    // decode applies only with independent gain selected
    always_ff @(posedge clk) begin
      if (!nrst) begin
        analog_cfg.gain_apply[c] <= 1'b0;
        analog_cfg.gain_db[c] <= 5'h00;
      end else begin
        analog_cfg.gain_apply[c] <= indep_gain_reg && (gain_code_t'(ch_gain_reg[c]) != GAIN_RSVD);
        case (gain_code_t'(ch_gain_reg[c]))
          GAIN_18DB: analog_cfg.gain_db[c] <= indep_gain_reg ? `GAIN_DB_00 : 5'h00;
          GAIN_24DB: analog_cfg.gain_db[c] <= indep_gain_reg ? `GAIN_DB_01 : 5'h00;
          GAIN_12DB: analog_cfg.gain_db[c] <= indep_gain_reg ? `GAIN_DB_10 : 5'h00;
          default: analog_cfg.gain_db[c] <= 5'h00;
        endcase
      end
    end
    assign ch_rsvd[c] = indep_gain_reg && (gain_code_t'(ch_gain_reg[c]) == GAIN_RSVD);
  end

  // ****************************************************************
  // Attenuator and high-pass corner register
  // ****************************************************************
  logic atten_en_reg;
  logic [2:0] atten_code_reg;
  logic [1:0] hpf_sel_reg;

  // reserved bits 15-8 and 1-0 are not stored
  always_ff @(posedge clk) begin
    if (!nrst) begin
      atten_en_reg <= 1'(`REG_RESET >> `BIT_ATTEN_EN);
      atten_code_reg <= 3'(`REG_RESET >> `LSB_ATTEN_CODE);
      hpf_sel_reg <= 2'(`REG_RESET >> `LSB_HPF_SEL);
    end else if (wr_atten) begin
      atten_en_reg <= bus_req.hwdata[`BIT_ATTEN_EN];
      atten_code_reg <= bus_req.hwdata[`LSB_ATTEN_CODE+:3];
      hpf_sel_reg <= bus_req.hwdata[`LSB_HPF_SEL+:2];
    end
  end

  // ****************************************************************
  // Clamp and filter option register
  // ****************************************************************
  logic half_clamp_reg;
  logic harm_filt_reg;
  logic conv_clamp_reg;
  logic div3_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      half_clamp_reg <= 1'(`REG_RESET >> `BIT_HALF_CLAMP);
      harm_filt_reg <= 1'(`REG_RESET >> `BIT_HARM_FILT);
      conv_clamp_reg <= 1'(`REG_RESET >> `BIT_CONV_CLAMP);
      div3_reg <= 1'(`REG_RESET >> `BIT_DIV3);
    end else if (wr_clamp) begin
      half_clamp_reg <= bus_req.hwdata[`BIT_HALF_CLAMP];
      harm_filt_reg <= bus_req.hwdata[`BIT_HARM_FILT];
      conv_clamp_reg <= bus_req.hwdata[`BIT_CONV_CLAMP];
      div3_reg <= bus_req.hwdata[`BIT_DIV3];
    end
  end

  // ****************************************************************
  // Analog settings
  // ****************************************************************
  logic [17:0] corner_base;

  always_comb begin
    case (hpf_sel_reg)
      2'h0: corner_base = `HPF_HZ_00;
      2'h1: corner_base = `HPF_HZ_01;
      2'h2: corner_base = `HPF_HZ_10;
      default: corner_base = `HPF_HZ_11;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      analog_cfg.atten_enable <= 1'b0;
      analog_cfg.atten_db <= 6'h00;
    end else begin
      analog_cfg.atten_enable <= atten_en_reg;
      // six dB per code step only while enabled
      analog_cfg.atten_db <= atten_en_reg ? 6'(6'(atten_code_reg) * `ATTEN_STEP_DB) : 6'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      analog_cfg.corner_hz <= `HPF_HZ_00;
    end else begin
      analog_cfg.corner_hz <= div3_reg ? corner_base / `HPF_DIVISOR : corner_base;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      analog_cfg.half_level_clamp <= 1'b0;
      analog_cfg.harmonic_suppress_filter <= 1'b0;
      analog_cfg.converter_stage_clamp <= 1'b0;
    end else begin
      analog_cfg.half_level_clamp <= half_clamp_reg;
      analog_cfg.harmonic_suppress_filter <= harm_filt_reg;
      analog_cfg.converter_stage_clamp <= conv_clamp_reg;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [31:0] rd_word;
  logic [7:0] gain_even;

  for (genvar q = 0; q < PAIRS; q++) begin : g_rd
    assign gain_even[2*q+:2] = ch_gain_reg[2*q+1];
  end

  // Unmapped reads and reserved bits return zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (idx_reg)
      `IDX_GAIN_CTRL: begin
        rd_word[`BIT_INDEP_GAIN] = indep_gain_reg;
        rd_word[`BIT_PAIR_OFFSET] = pair_offset_reg;
      end
      `IDX_CFG_STATUS: begin
        rd_word[5:0] = analog_cfg.atten_db;
        rd_word[`BIT_STAT_RSVD] = |ch_rsvd;
      end
      `IDX_GAIN_PAIR: rd_word[7:0] = gain_even;
      `IDX_ATTEN_HPF: begin
        rd_word[`BIT_ATTEN_EN] = atten_en_reg;
        rd_word[`LSB_ATTEN_CODE+:3] = atten_code_reg;
        rd_word[`LSB_HPF_SEL+:2] = hpf_sel_reg;
      end
      `IDX_CLAMP_OPT: begin
        rd_word[`BIT_HALF_CLAMP] = half_clamp_reg;
        rd_word[`BIT_HARM_FILT] = harm_filt_reg;
        rd_word[`BIT_CONV_CLAMP] = conv_clamp_reg;
        rd_word[`BIT_DIV3] = div3_reg;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_reg && !rd_wait_reg) begin
      hrdata <= rd_word;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_gain_gate_off: assert property (!indep_gain_reg |=> analog_cfg.gain_db == '0)
    else $error("gain applied while independent gain is off");
  a_gain_decode: assert property (indep_gain_reg && ch_gain_reg[1] == 2'h1 |=> analog_cfg.gain_db[1] == 5'h18)
    else $error("code 01 did not give 24 dB");
  a_offset_keeps_odd: assert property (wr_gain_pair && pair_offset_reg |=> $stable(ch_gain_reg[0]))
    else $error("odd channel changed under pair offset");
  a_both_ch_write: assert property (wr_gain_pair && !pair_offset_reg
      |=> ch_gain_reg[6] == $past(bus_req.hwdata[7:6]) && ch_gain_reg[7] == ch_gain_reg[6])
    else $error("pair 7/8 not written from bits 7-6");
  a_atten_disable: assert property (!atten_en_reg |=> !analog_cfg.atten_enable && analog_cfg.atten_db == 6'h00)
    else $error("attenuation active while disabled");
  a_atten_max: assert property (atten_en_reg && atten_code_reg == 3'h7 |=> analog_cfg.atten_db == 6'h2a)
    else $error("code 111 did not give 42 dB");
  a_corner_50k: assert property (hpf_sel_reg == 2'h1 && !div3_reg |=> analog_cfg.corner_hz == 18'h0c350)
    else $error("code 01 did not give 50 kHz");
  a_corner_div3: assert property (hpf_sel_reg == 2'h2 && div3_reg |=> analog_cfg.corner_hz == 18'h1046a)
    else $error("200 kHz corner not divided by three");
  a_rsvd_zero: assert property (wr_atten ##2 rd_pend_reg && idx_reg == `IDX_ATTEN_HPF && !rd_wait_reg
      |=> hrdata[15:8] == 8'h00 && hrdata[1:0] == 2'h0)
    else $error("reserved bits read nonzero");
  a_read_wait: assert property (rd_pend_reg && !rd_wait_reg |-> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");

  c_offset_write: cover property (wr_gain_pair && pair_offset_reg);
  c_div3_corner: cover property (div3_reg && hpf_sel_reg == 2'h3);
  c_full_atten: cover property (analog_cfg.atten_db == 6'h2a);
  c_wr_then_rd: cover property (wr_pend_reg && addr_take && !bus_req.hwrite);
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking testbench for the front-end gain and filter configuration bank
`timescale 1ns/1ns
`include "fe_cfg_map.svh"
`default_nettype none
module tb;
  import fe_cfg_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  ahb_req_t req = '0;
  ahb_req_t bus_req;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  analog_cfg_t analog_cfg;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [1:0] code_m [8];
  logic indep_m = 1'b0;
  logic [15:0] atten_m = 16'h0000;
  logic [15:0] opt_m = 16'h0000;
  logic [7:0] v;
  logic [11:0] addrs [5] = '{12'h310, 12'h314, 12'h324, 12'h32c, 12'h334};

  always #25 clk = ~clk;

  // Single slave, so its hreadyout is the bus hready
  always_comb begin
    bus_req = req;
    bus_req.hready = hreadyout;
  end

  frontend_gain_filter_config_regs #(.ADDR_W(12), .PAIRS(4)) i_frontend_gain_filter_config_regs (
    .clk(clk),
    .nrst(nrst),
    .bus_req(bus_req),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .analog_cfg(analog_cfg)
  );

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic report_and_stop();
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // Bus tasks, entered and left just after a rising edge
  // ****************************************************************
  task automatic wait_ready();
    do @(negedge clk); while (hreadyout !== 1'b1);
  endtask

  task automatic bus_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    req.hsel <= 1'b1;
    req.haddr <= a;
    req.htrans <= 2'b10;
    req.hwrite <= wr;
    req.hsize <= 3'b010;
    wait_ready();
    @(posedge clk);
    req.hsel <= 1'b0;
    req.htrans <= 2'b00;
    req.hwdata <= d;
    wait_ready();
    q = hrdata;
    compare(32'(hresp), 32'h0);
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_xfer(1'b0, a, 32'h0, q);
    compare(q, exp);
  endtask

  // Model keeps per-channel codes so the offset control can be followed
  task automatic gain_wr(input logic [7:0] d, input logic offs);
    wr(12'h324, {24'h0, d});
    for (int c = 0; c < 8; c++) begin
      if (!offs || c % 2 == 1) begin
        code_m[c] = d[2 * (c / 2) +: 2];
      end
    end
  endtask

  function automatic logic [31:0] exp_status();
    logic odd;
    odd = 1'b0;
    for (int c = 0; c < 8; c++) begin
      odd = odd | (code_m[c] == 2'b11);
    end
    exp_status = {23'h0, indep_m & odd, 8'h00};
    if (atten_m[7]) begin
      exp_status[5:0] = 6'(32'(`ATTEN_STEP_DB) * 32'(atten_m[6:4]));
    end
  endfunction

  task automatic check_cfg();
    logic [17:0] base;
    logic [4:0] db;
    @(posedge clk);
    @(negedge clk);
    for (int c = 0; c < 8; c++) begin
      case (code_m[c])
        2'b00: db = `GAIN_DB_00;
        2'b01: db = `GAIN_DB_01;
        2'b10: db = `GAIN_DB_10;
        default: db = 5'h00;
      endcase
      compare(32'(analog_cfg.gain_db[c]), indep_m ? 32'(db) : 32'h0);
      compare(32'(analog_cfg.gain_apply[c]), 32'(indep_m && code_m[c] != 2'b11));
    end
    compare(32'(analog_cfg.atten_enable), 32'(atten_m[7]));
    compare(32'(analog_cfg.atten_db), atten_m[7] ? 32'(`ATTEN_STEP_DB) * 32'(atten_m[6:4]) : 32'h0);
    case (atten_m[3:2])
      2'b00: base = `HPF_HZ_00;
      2'b01: base = `HPF_HZ_01;
      2'b10: base = `HPF_HZ_10;
      default: base = `HPF_HZ_11;
    endcase
    compare(32'(analog_cfg.corner_hz), opt_m[8] ? 32'(base / `HPF_DIVISOR) : 32'(base));
    compare(32'({analog_cfg.half_level_clamp, analog_cfg.harmonic_suppress_filter,
      analog_cfg.converter_stage_clamp}), 32'(opt_m[15:13]));
    @(posedge clk);
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    for (int c = 0; c < 8; c++) begin
      code_m[c] = 2'b00;
    end
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (addrs[i]) begin
      rd_chk(addrs[i], 32'h0);
    end
    check_cfg();
    wr(12'h310, 32'h00008000);
    indep_m = 1'b1;
    v = 8'h1b;
    for (int k = 0; k < 4; k++) begin
      gain_wr(v, 1'b0);
      check_cfg();
      rd_chk(12'h324, {24'h0, v});
      rd_chk(12'h314, exp_status());
      v = {v[5:0], v[7:6]};
    end
    // Offset control set: only even channels take the new codes
    wr(12'h310, 32'h00008001);
    gain_wr(8'he4, 1'b1);
    check_cfg();
    rd_chk(12'h324, {24'h0, code_m[7], code_m[5], code_m[3], code_m[1]});
    wr(12'h310, 32'h00000000);
    indep_m = 1'b0;
    check_cfg();
    rd_chk(12'h314, exp_status());
    wr(12'h310, 32'h00008000);
    indep_m = 1'b1;
    for (int e = 0; e < 2; e++) begin
      for (int k = 0; k < 8; k++) begin
        opt_m = e[0] ? 16'h0100 : 16'h0000;
        atten_m = {8'h00, e[0], k[2:0], k[1:0], 2'b00};
        wr(12'h334, {16'h0, opt_m});
        wr(12'h32c, {16'h0, atten_m});
        check_cfg();
        rd_chk(12'h32c, {16'h0, atten_m});
        rd_chk(12'h314, exp_status());
      end
    end
    // Every defined field set, reserved positions kept at zero
    wr(12'h32c, 32'h000000fc);
    atten_m = 16'h00fc;
    rd_chk(12'h32c, 32'h000000fc);
    wr(12'h334, 32'h0000e100);
    opt_m = 16'he100;
    rd_chk(12'h334, 32'h0000e100);
    check_cfg();
    wr(12'h334, 32'h00004000);
    opt_m = 16'h4000;
    check_cfg();
    // Unmapped and aliased addresses are ignored and read zero
    wr(12'h72c, 32'h00000000);
    rd_chk(12'h32c, 32'h000000fc);
    rd_chk(12'h72c, 32'h00000000);
    rd_chk(12'h3f0, 32'h00000000);
    report_and_stop();
  end
endmodule
`default_nettype wire
